// [src/swc_top.sv]
// Switching clock generation, sync handling and strap configuration
// What this block does
// - Sample straps once after reset, then run
// - Divide reference by integer 30 to 150
// - Round requested frequency to nearest divisor
// - Frequency from sync strap or command 33h
// - Switching clock may follow external sync
// - Drive sync pin out on internal clock
// - Follow any in-range external frequency
// - Lost sync sets fault bit, shuts down
// - After loss, re-enable on internal clock
// - Resync only at reset or config command
// - One strap sets set point and address
// - Config storable and readable by command
`timescale 1ns/1ns
module swc_top #(
	parameter int POR_CYCLES = swc_pkg::POR_SYNC_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        ref_tick,
	input  wire logic        en,
	input  wire logic        strap_valid,
	input  wire logic [3:0]  sync_strap_code,
	input  wire logic        sync_strap_open,
	input  wire logic [4:0]  setpoint_strap_row,
	input  wire logic [2:0]  setpoint_strap_col,
	input  wire logic        sync_i,
	output logic             sync_o,
	output logic             sync_oe,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [15:0] cmd_wdata,
	output logic             rsp_valid,
	output logic             rsp_err,
	output logic      [15:0] rsp_data,
	output logic             nv_save,
	output logic             sw_clk,
	output logic             pll_ext_sel,
	output logic             out_enable,
	output logic      [4:0]  setpoint_code,
	output logic      [6:0]  bus_address
);
	localparam int CW = 22;
	localparam logic [CW-1:0] POR_LAST = CW'(POR_CYCLES - 1);
	swc_pkg::swc_state_e state, next_state;
	logic [15:0] freq_set, next_freq_set;
	logic [7:0]  divisor, next_divisor;
	logic [1:0]  user_cfg, next_user_cfg;
	logic        ext_mode, next_ext_mode;
	logic        por_wait, next_por_wait;
	logic [CW-1:0] por_cnt, next_por_cnt;
	logic [7:0]  loss_cnt, next_loss_cnt;
	logic        fault, next_fault;
	logic        shut, next_shut;
	logic        sync_q;
	logic [7:0]  ph_cnt, next_ph_cnt;
	logic        next_sw_clk;
	logic        next_rsp_valid, next_rsp_err, next_nv_save;
	logic [15:0] next_rsp_data;
	logic [4:0]  next_setpoint;
	logic [6:0]  next_address;
	logic        sync_edge, loss_hit, div_start, div_busy, div_done;
	logic [15:0] div_den, div_quo, strap_khz;
	logic        wr_freq, wr_cfg, clr_fault;

	// Rising sync edge, pin is already synchronous
	assign sync_edge = sync_i && !sync_q;
	assign loss_hit  = ext_mode && ref_tick && !sync_edge &&
		(loss_cnt == swc_pkg::LOSS_REF_CYCLES - 8'h01);
	assign wr_freq   = cmd_valid && cmd_write &&
		(cmd_code == swc_pkg::CMD_FREQ_SWITCH) && state == swc_pkg::ST_RUN;
	assign wr_cfg    = cmd_valid && cmd_write &&
		(cmd_code == swc_pkg::CMD_USER_CONFIG);
	assign clr_fault = cmd_valid && cmd_write &&
		(cmd_code == swc_pkg::CMD_CLEAR_FAULTS);
	assign strap_khz = sync_strap_open ? swc_pkg::FREQ_OPEN_KHZ :
		swc_pkg::STRAP_KHZ[sync_strap_code];

	// Divider operand: clamped frequency, rounded by half divisor
	always_comb begin
		div_den = wr_freq ? cmd_wdata : strap_khz;
		if (div_den < swc_pkg::FREQ_MIN_KHZ) begin
			div_den = swc_pkg::FREQ_MIN_KHZ;
		end else if (div_den > swc_pkg::FREQ_MAX_KHZ) begin
			div_den = swc_pkg::FREQ_MAX_KHZ;
		end
	end
	assign div_start = (state == swc_pkg::ST_STRAP && strap_valid) || wr_freq;

	swc_divider u_div (
		.mclk  (mclk),
		.nrst  (nrst),
		.start (div_start),
		.num   (swc_pkg::REF_KHZ + {1'b0, div_den[15:1]}),
		.den   (div_den),
		.quo   (div_quo),
		.busy  (div_busy),
		.done  (div_done)
	);

	// Configuration, mode, loss and fault next values
	always_comb begin
		next_state    = state;
		next_freq_set = freq_set;
		next_divisor  = divisor;
		next_user_cfg = user_cfg;
		next_ext_mode = ext_mode;
		next_por_wait = por_wait;
		next_por_cnt  = por_cnt;
		next_loss_cnt = loss_cnt;
		next_fault    = fault;
		next_shut     = shut;
		next_setpoint = setpoint_code;
		next_address  = bus_address;
		case (state)
			swc_pkg::ST_STRAP: begin
				if (strap_valid) begin
					next_freq_set = strap_khz;
					next_setpoint = setpoint_strap_row;
					next_address  = swc_pkg::ADDR_BASE +
						{4'h0, setpoint_strap_col};
					next_state    = swc_pkg::ST_CALC;
				end
			end
			swc_pkg::ST_CALC: begin
				if (div_done) begin
					next_state = swc_pkg::ST_RUN;
				end
			end
			swc_pkg::ST_RUN: begin
				if (wr_freq) begin
					next_freq_set = cmd_wdata;
					next_state    = swc_pkg::ST_CALC;
				end
			end
			default: next_state = swc_pkg::ST_STRAP;
		endcase
		// Nearest whole divisor, held inside its legal span
		if (div_done) begin
			if (div_quo < {8'h00, swc_pkg::DIV_MIN}) begin
				next_divisor = swc_pkg::DIV_MIN;
			end else if (div_quo > {8'h00, swc_pkg::DIV_MAX}) begin
				next_divisor = swc_pkg::DIV_MAX;
			end else begin
				next_divisor = div_quo[7:0];
			end
		end
		// Lock to sync in the window after reset, or by config command
		if (por_wait) begin
			next_por_cnt = por_cnt + CW'(1);
			if (sync_edge) begin
				next_ext_mode = 1'b1;
				next_por_wait = 1'b0;
			end else if (por_cnt == POR_LAST) begin
				next_por_wait = 1'b0;
			end
		end
		if (wr_cfg) begin
			next_user_cfg = cmd_wdata[1:0];
			next_ext_mode = cmd_wdata[swc_pkg::CFG_EXT_SEL_BIT];
			next_por_wait = 1'b0;
		end
		// Reference cycles since the last sync edge
		if (!ext_mode || sync_edge) begin
			next_loss_cnt = 8'h00;
		end else if (ref_tick) begin
			next_loss_cnt = loss_cnt + 8'h01;
		end
		if (clr_fault) begin
			next_fault = 1'b0;
		end
		if (!en) begin
			next_shut = 1'b0;
		end
		if (loss_hit) begin
			next_fault    = 1'b1;
			next_shut     = 1'b1;
			next_ext_mode = 1'b0;
			next_loss_cnt = 8'h00;
		end
	end

	// Internal divided clock, or the external sync when locked
	always_comb begin
		next_ph_cnt = ph_cnt;
		next_sw_clk = sw_clk;
		if (ext_mode) begin
			next_ph_cnt = 8'h00;
			next_sw_clk = sync_i;
		end else if (ref_tick) begin
			if (ph_cnt >= divisor - 8'h01) begin
				next_ph_cnt = 8'h00;
			end else begin
				next_ph_cnt = ph_cnt + 8'h01;
			end
			next_sw_clk = next_ph_cnt < {1'b0, divisor[7:1]};
		end
	end

	// Command answers, one cycle after the request
	always_comb begin
		next_rsp_valid = cmd_valid;
		next_rsp_err   = 1'b0;
		next_rsp_data  = 16'h0000;
		next_nv_save   = 1'b0;
		if (cmd_valid) begin
			if (cmd_code == swc_pkg::CMD_FREQ_SWITCH) begin
				next_rsp_data = freq_set;
				next_rsp_err  = cmd_write && state != swc_pkg::ST_RUN;
			end else if (cmd_code == swc_pkg::CMD_FAULT_STATUS) begin
				next_rsp_data = 16'h0000;
				next_rsp_data[swc_pkg::FAULT_EXT_PERIOD_BIT] = fault;
				next_rsp_err  = cmd_write;
			end else if (cmd_code == swc_pkg::CMD_USER_CONFIG) begin
				next_rsp_data = {14'h0000, user_cfg};
			end else if (cmd_code == swc_pkg::CMD_CLEAR_FAULTS) begin
				next_rsp_err  = !cmd_write;
			end else if (cmd_code == swc_pkg::CMD_STORE_USER) begin
				next_nv_save  = cmd_write;
				next_rsp_err  = !cmd_write;
			end else begin
				next_rsp_err  = 1'b1;
			end
		end
	end

	// Register stage for all state
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state         <= swc_pkg::ST_STRAP;
			freq_set      <= swc_pkg::FREQ_OPEN_KHZ;
			divisor       <= swc_pkg::DIV_RESET;
			user_cfg      <= swc_pkg::CFG_RESET;
			ext_mode      <= 1'b0;
			por_wait      <= 1'b1;
			por_cnt       <= '0;
			loss_cnt      <= 8'h00;
			fault         <= 1'b0;
			shut          <= 1'b0;
			sync_q        <= 1'b0;
			ph_cnt        <= 8'h00;
			sw_clk        <= 1'b0;
			rsp_valid     <= 1'b0;
			rsp_err       <= 1'b0;
			rsp_data      <= 16'h0000;
			nv_save       <= 1'b0;
			setpoint_code <= 5'h00;
			bus_address   <= 7'h00;
		end else begin
			state         <= next_state;
			freq_set      <= next_freq_set;
			divisor       <= next_divisor;
			user_cfg      <= next_user_cfg;
			ext_mode      <= next_ext_mode;
			por_wait      <= next_por_wait;
			por_cnt       <= next_por_cnt;
			loss_cnt      <= next_loss_cnt;
			fault         <= next_fault;
			shut          <= next_shut;
			sync_q        <= sync_i;
			ph_cnt        <= next_ph_cnt;
			sw_clk        <= next_sw_clk;
			rsp_valid     <= next_rsp_valid;
			rsp_err       <= next_rsp_err;
			rsp_data      <= next_rsp_data;
			nv_save       <= next_nv_save;
			setpoint_code <= next_setpoint;
			bus_address   <= next_address;
		end
	end

	// Pin and status outputs
	assign pll_ext_sel = ext_mode;
	assign sync_oe     = !ext_mode && !por_wait &&
		user_cfg[swc_pkg::CFG_SYNC_OUT_BIT];
	assign sync_o      = sw_clk;
	assign out_enable  = en && !shut && state != swc_pkg::ST_STRAP;

	// Checks
	property p_strap_once;
		@(posedge mclk) disable iff (!nrst)
		state != swc_pkg::ST_STRAP |=> $stable(bus_address) &&
			$stable(setpoint_code);
	endproperty
	a_strap_once: assert property (p_strap_once)
		else $error("strap result changed after sampling");
	property p_div_range;
		@(posedge mclk) disable iff (!nrst)
		state == swc_pkg::ST_RUN |-> divisor >= swc_pkg::DIV_MIN &&
			divisor <= swc_pkg::DIV_MAX;
	endproperty
	a_div_range: assert property (p_div_range)
		else $error("divisor outside 30 to 150");
	property p_round;
		@(posedge mclk) disable iff (!nrst)
		div_start && !div_busy && div_den == 16'h0253 |-> ##18 divisor == 8'h32;
	endproperty
	a_round: assert property (p_round)
		else $error("595 kHz did not select divisor 50");
	property p_freq_cmd;
		@(posedge mclk) disable iff (!nrst)
		wr_freq |=> state == swc_pkg::ST_CALC && freq_set == $past(cmd_wdata);
	endproperty
	a_freq_cmd: assert property (p_freq_cmd)
		else $error("frequency write not taken");
	property p_open;
		@(posedge mclk) disable iff (!nrst)
		state == swc_pkg::ST_STRAP && strap_valid && sync_strap_open
			|=> freq_set == swc_pkg::FREQ_OPEN_KHZ;
	endproperty
	a_open: assert property (p_open)
		else $error("open strap did not give 500 kHz");
	property p_follow;
		@(posedge mclk) disable iff (!nrst)
		ext_mode ##1 ext_mode |-> sw_clk == $past(sync_i);
	endproperty
	a_follow: assert property (p_follow)
		else $error("switching clock not following sync");
	property p_sync_out;
		@(posedge mclk) disable iff (!nrst)
		sync_oe |-> !ext_mode &&
			(!$changed(sync_o) || $past(ref_tick) || $past(ext_mode));
	endproperty
	a_sync_out: assert property (p_sync_out)
		else $error("sync output not the internal divided clock");
	property p_loss;
		@(posedge mclk) disable iff (!nrst)
		loss_hit |=> fault && shut && !ext_mode && !out_enable;
	endproperty
	a_loss: assert property (p_loss)
		else $error("loss of sync not handled");
	property p_stay_int;
		@(posedge mclk) disable iff (!nrst)
		!ext_mode && !por_wait && !wr_cfg |=> !ext_mode;
	endproperty
	a_stay_int: assert property (p_stay_int)
		else $error("external mode resumed without cause");
	property p_sticky;
		@(posedge mclk) disable iff (!nrst)
		fault && !clr_fault |=> fault;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("fault bit dropped without clear");
	property p_store;
		@(posedge mclk) disable iff (!nrst)
		cmd_valid && cmd_write && cmd_code == swc_pkg::CMD_STORE_USER
			|=> nv_save && rsp_valid;
	endproperty
	a_store: assert property (p_store)
		else $error("store command not forwarded");
	c_run: cover property (@(posedge mclk) disable iff (!nrst)
		state == swc_pkg::ST_CALC ##1 state == swc_pkg::ST_RUN);
	c_lock: cover property (@(posedge mclk) disable iff (!nrst)
		por_wait && sync_edge);
	c_loss: cover property (@(posedge mclk) disable iff (!nrst) loss_hit);
endmodule

// [src/swc_pkg.sv]
// Constants for the switching clock, sync and strap block
package swc_pkg;
	// Command codes on the management port
	localparam logic [7:0] CMD_FREQ_SWITCH  = 8'h33;
	localparam logic [7:0] CMD_FAULT_STATUS = 8'h80;
	localparam logic [7:0] CMD_USER_CONFIG  = 8'hD1;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_STORE_USER   = 8'h15;
	// Fault status and user configuration fields
	localparam int         FAULT_EXT_PERIOD_BIT = 3;
	localparam int         CFG_EXT_SEL_BIT      = 0;
	localparam int         CFG_SYNC_OUT_BIT     = 1;
	localparam logic [1:0] CFG_RESET            = 2'h0;
	// Frequency arithmetic, frequencies in kHz, divisors in reference cycles
	localparam logic [15:0] REF_KHZ       = 16'h7530;
	localparam logic [15:0] FREQ_MIN_KHZ  = 16'h00C8;
	localparam logic [15:0] FREQ_MAX_KHZ  = 16'h03E8;
	localparam logic [15:0] FREQ_OPEN_KHZ = 16'h01F4;
	localparam logic [7:0]  DIV_MIN       = 8'h1E;
	localparam logic [7:0]  DIV_MAX       = 8'h96;
	localparam logic [7:0]  DIV_RESET     = 8'h3C;
	// Sixteen strap codes to switching frequency in kHz
	localparam logic [15:0] STRAP_KHZ [16] = '{
		16'h00FA, 16'h012C, 16'h0161, 16'h0190,
		16'h01C7, 16'h01F4, 16'h0221, 16'h0258,
		16'h028C, 16'h02BA, 16'h02EE, 16'h032B,
		16'h0359, 16'h038D, 16'h03C8, 16'h03E8};
	// Bus address base for the combined set point and address strap
	localparam logic [6:0] ADDR_BASE = 7'h60;
	// Timing: sync must appear within this time after reset
	localparam int POR_SYNC_MS     = 50;
	localparam int CLK_KHZ         = 50000;
	localparam int POR_SYNC_CYCLES = POR_SYNC_MS * CLK_KHZ;
	// Loss window in reference cycles, beyond the slowest period
	localparam logic [7:0] LOSS_REF_CYCLES = 8'hC8;
	typedef enum logic [1:0] {
		ST_STRAP = 2'b00,
		ST_CALC  = 2'b01,
		ST_RUN   = 2'b11
	} swc_state_e;
endpackage

// [src/swc_divider.sv]
// Sequential restoring divider for the switching period divisor
`timescale 1ns/1ns
module swc_divider (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        start,
	input  wire logic [15:0] num,
	input  wire logic [15:0] den,
	output logic      [15:0] quo,
	output logic             busy,
	output logic             done
);
	logic [16:0] rem;
	logic [3:0]  cnt;
	logic [16:0] next_rem;
	logic [15:0] next_quo;
	logic [3:0]  next_cnt;
	logic        next_busy;
	logic        next_done;
	logic [16:0] shifted;
	logic [15:0] den_q;
	logic [15:0] next_den;

	// One quotient bit per cycle, sixteen cycles per division
	always_comb begin
		shifted   = {rem[15:0], quo[15]};
		next_rem  = rem;
		next_quo  = quo;
		next_cnt  = cnt;
		next_busy = busy;
		next_done = 1'b0;
		next_den  = den_q;
		// Divisor held for the whole division; the caller's operand may move
		if (start && !busy) begin
			next_rem  = 17'h00000;
			next_quo  = num;
			next_den  = den;
			next_cnt  = 4'h0;
			next_busy = 1'b1;
		end else if (busy) begin
			if (shifted >= {1'b0, den_q}) begin
				next_rem = shifted - {1'b0, den_q};
				next_quo = {quo[14:0], 1'b1};
			end else begin
				next_rem = shifted;
				next_quo = {quo[14:0], 1'b0};
			end
			next_cnt = cnt + 4'h1;
			if (cnt == 4'hF) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	// Register stage
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rem  <= 17'h00000;
			quo  <= 16'h0000;
			cnt  <= 4'h0;
			busy <= 1'b0;
			done <= 1'b0;
			den_q <= 16'h0000;
		end else begin
			rem  <= next_rem;
			quo  <= next_quo;
			cnt  <= next_cnt;
			busy <= next_busy;
			done <= next_done;
			den_q <= next_den;
		end
	end
endmodule

// [test/swc_sync_src.sv]
// External sync clock source model facing the sync pin
`timescale 1ns/1ns
module swc_sync_src (
	input  wire logic       mclk,
	input  wire logic       run,
	input  wire logic [7:0] half,
	output logic            sync_drv
);
	int cnt = 0;

	// Square wave while running; pulled-down line stays low when stopped
	always @(negedge mclk) begin
		if (!run) begin
			cnt <= 0;
			sync_drv <= 1'b0;
		end else if (cnt >= int'(half) - 1) begin
			cnt <= 0;
			sync_drv <= !sync_drv;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// [test/testbench.sv]
// Self-checking bench for the switching clock and strap block
`timescale 1ns/1ns
module testbench;
	logic        mclk         = 1'b0;
	logic        nrst         = 1'b0;
	logic        ref_tick     = 1'b0;
	logic        en           = 1'b0;
	logic        strap_valid  = 1'b0;
	logic [3:0]  s_code       = 4'h0;
	logic        s_open       = 1'b0;
	logic [4:0]  s_row        = 5'h00;
	logic [2:0]  s_col        = 3'h0;
	logic        src_run      = 1'b0;
	logic        cmd_valid    = 1'b0;
	logic        cmd_write    = 1'b0;
	logic [7:0]  cmd_code     = 8'h00;
	logic [15:0] cmd_wdata    = 16'h0000;
	logic        sync_pin;
	logic        sync_o;
	logic        sync_oe;
	logic        src_out;
	logic        rsp_valid;
	logic        rsp_err;
	logic        nv_save;
	logic        sw_clk;
	logic        pll_ext_sel;
	logic        out_enable;
	logic [15:0] rsp_data;
	logic [4:0]  setpoint_code;
	logic [6:0]  bus_address;
	logic [15:0] rd;
	logic        er;
	logic        sv;
	int          failures     = 0;
	int          tests_run    = 0;
	int          ph           = 0;
	int          n;
	int          fr [5]       = '{595, 1000, 200, 150, 698};

	// Clock, 3-of-5 reference ticks, resolved sync pin
	always #10 mclk = ~mclk;
	always @(negedge mclk) begin
		ph <= (ph + 1) % 5;
		ref_tick <= (ph < 3);
	end
	assign sync_pin = sync_oe ? sync_o : src_out;

	swc_top #(.POR_CYCLES(200)) swc_top_i (
		.mclk(mclk), .nrst(nrst), .ref_tick(ref_tick), .en(en),
		.strap_valid(strap_valid), .sync_strap_code(s_code),
		.sync_strap_open(s_open), .setpoint_strap_row(s_row),
		.setpoint_strap_col(s_col), .sync_i(sync_pin), .sync_o(sync_o),
		.sync_oe(sync_oe), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
		.rsp_err(rsp_err), .rsp_data(rsp_data), .nv_save(nv_save),
		.sw_clk(sw_clk), .pll_ext_sel(pll_ext_sel),
		.out_enable(out_enable), .setpoint_code(setpoint_code),
		.bus_address(bus_address)
	);
	swc_sync_src swc_sync_src_i (
		.mclk(mclk), .run(src_run), .half(8'h1F), .sync_drv(src_out)
	);

	// Comparisons
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One command: taken at c0, answer sampled while it stands in c1
	task automatic cmd(input logic wr, input logic [7:0] code,
			input logic [15:0] wd);
		@(negedge mclk);
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_code = code;
		cmd_wdata = wd;
		@(negedge mclk);
		cmd_valid = 1'b0;
		rd = rsp_data;
		er = rsp_err;
		sv = nv_save;
		chk_flag(rsp_valid, 1'b1);
	endtask

	// Present strap codes for one cycle, then let the divisor settle
	task automatic strap(input logic op, input logic [3:0] c,
			input logic [4:0] r, input logic [2:0] a);
		@(negedge mclk);
		s_open = op;
		s_code = c;
		s_row = r;
		s_col = a;
		strap_valid = 1'b1;
		@(negedge mclk);
		strap_valid = 1'b0;
		repeat (20) @(negedge mclk);
	endtask

	// Ticks (or cycles) between two rising edges of the switching clock
	task automatic period(input logic ticks, output int cnt);
		logic p;
		int k;
		p = sw_clk;
		cnt = 0;
		for (k = 0; k < 2000 && !(!p && sw_clk); k++) begin
			p = sw_clk;
			@(negedge mclk);
		end
		p = 1'b1;
		for (k = 0; k < 2000 && !(!p && sw_clk === 1'b1); k++) begin
			p = sw_clk;
			@(negedge mclk);
			cnt += ticks ? int'(ref_tick) : 1;
		end
	endtask

	// Divisor a host should expect for a requested frequency in kHz
	function automatic int div_for(input int f);
		int q;
		q = (f < 200) ? 200 : (f > 1000) ? 1000 : f;
		q = (30000 + q / 2) / q;
		return (q < 30) ? 30 : (q > 150) ? 150 : q;
	endfunction

	task automatic close_out();
		$display("checks=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		#400000;
		failures++;
		close_out();
	end

	initial begin
		en = 1'b1;
		repeat (3) @(negedge mclk);
		nrst = 1'b1;
		chk_flag(out_enable, 1'b0);
		strap(1'b1, 4'h2, 5'h04, 3'h2);
		chk_word(16'(setpoint_code), 16'h0004);
		chk_word(16'(bus_address), 16'h0062);
		chk_flag(out_enable, 1'b1);
		cmd(1'b0, 8'h33, 16'h0000);
		chk_word(rd, 16'h01F4);
		strap(1'b0, 4'hF, 5'h09, 3'h7);
		chk_word(16'(bus_address), 16'h0062);
		period(1'b1, n);
		chk_word(16'(n), 16'h003C);
		$display("test straps done");
		repeat (200) @(negedge mclk);
		cmd(1'b1, 8'hD1, 16'h0002);
		@(negedge mclk);
		chk_flag(sync_oe, 1'b1);
		chk_flag(pll_ext_sel, 1'b0);
		for (int i = 0; i < 5; i++) begin
			cmd(1'b1, 8'h33, 16'(fr[i]));
			chk_flag(er, 1'b0);
			repeat (20) @(negedge mclk);
			cmd(1'b0, 8'h33, 16'h0000);
			chk_word(rd, 16'(fr[i]));
			period(1'b1, n);
			chk_word(16'(n), 16'(div_for(fr[i])));
		end
		$display("test divisor done");
		cmd(1'b1, 8'h33, 16'h012C);
		cmd(1'b1, 8'h33, 16'h0190);
		chk_flag(er, 1'b1);
		repeat (20) @(negedge mclk);
		cmd(1'b0, 8'h33, 16'h0000);
		chk_word(rd, 16'h012C);
		cmd(1'b1, 8'h80, 16'h0001);
		chk_flag(er, 1'b1);
		cmd(1'b0, 8'h80, 16'h0000);
		chk_word({rd[15:1], er}, 16'h0000);
		cmd(1'b0, 8'h03, 16'h0000);
		chk_flag(er, 1'b1);
		cmd(1'b0, 8'h5A, 16'h0000);
		chk_word({rd[15:1], er}, 16'h0001);
		cmd(1'b1, 8'h15, 16'h0000);
		chk_word(16'({sv, er}), 16'h0002);
		$display("test commands done");
		nrst <= 1'b0;
		src_run <= 1'b1;
		repeat (3) @(negedge mclk);
		nrst <= 1'b1;
		// The same device reset and strapped to a new address
		strap(1'b0, 4'h9, 5'h01, 3'h5);
		chk_word(16'(bus_address), 16'h0065);
		cmd(1'b1, 8'h33, 16'h0326);
		repeat (20) @(negedge mclk);
		chk_flag(pll_ext_sel, 1'b1);
		period(1'b0, n);
		chk_word(16'(n), 16'h003E);
		$display("test external sync done");
		period(1'b0, n);
		src_run <= 1'b0;
		for (n = 0; n < 600 && out_enable === 1'b1; n++) @(negedge mclk);
		chk_flag(n >= 325 && n <= 345, 1'b1);
		chk_flag(pll_ext_sel, 1'b0);
		cmd(1'b0, 8'h80, 16'h0000);
		chk_flag(rd[3], 1'b1);
		en = 1'b0;
		repeat (2) @(negedge mclk);
		en = 1'b1;
		repeat (2) @(negedge mclk);
		chk_flag(out_enable, 1'b1);
		period(1'b1, n);
		chk_word(16'(n), 16'(div_for(806)));
		src_run <= 1'b1;
		repeat (200) @(negedge mclk);
		chk_flag(pll_ext_sel, 1'b0);
		cmd(1'b1, 8'hD1, 16'h0001);
		repeat (3) @(negedge mclk);
		chk_flag(pll_ext_sel, 1'b1);
		cmd(1'b1, 8'h03, 16'h0000);
		cmd(1'b0, 8'h80, 16'h0000);
		chk_flag(rd[3], 1'b0);
		$display("test loss and resync done");
		close_out();
	end
endmodule
